// ### logic/atpg_map.svh
`ifndef ATPG_MAP_SVH
`define ATPG_MAP_SVH
// Register byte offsets
`define ATPG_REG_CTRL      8'h00
`define ATPG_REG_RATE      8'h04
`define ATPG_REG_ROUTE     8'h08
`define ATPG_REG_STATUS    8'h0c
`define ATPG_REG_DISCARDS  8'h10
`define ATPG_REG_ACQ       8'h14
`define ATPG_REG_SHP_BASE  8'h20
`define ATPG_REG_SHP_STEP  8'h10
// Shaper sub offsets: width, delay, downscale
`define ATPG_SHP_WIDTH     2'h0
`define ATPG_SHP_DELAY     2'h1
`define ATPG_SHP_SCALE     2'h2
// Control fields
`define ATPG_CTRL_MODE     0
`define ATPG_CTRL_POL      1
`define ATPG_CTRL_SRC_LO   4
`define ATPG_CTRL_RUN_LO   8
// Run state codes
`define ATPG_RUN_IDLE      2'h0
`define ATPG_RUN_ACTIVE    2'h1
`define ATPG_RUN_HALT      2'h2
// Route fields: 4-bit selectors
`define ATPG_ROUTE_CAM_LO  0
`define ATPG_ROUTE_OUT0_LO 4
`define ATPG_ROUTE_OUT1_LO 8
// Route codes: 0..3 shaper true, 4..7 inverted, 8..11 general input
`define ATPG_SEL_INV       4'h4
`define ATPG_SEL_GPI       4'h8
// Reset values
`define ATPG_RATE_RST      32'h0000000a
`define ATPG_WIDTH_RST     32'h000000c8
`define ATPG_SCALE_RST     32'h00000001
// Timing
`define ATPG_CLK_HZ        40000000
`define ATPG_TICK_US       1
`define ATPG_ONE_MHZ       1000000
`define ATPG_TICK_CYC      ((`ATPG_CLK_HZ / `ATPG_ONE_MHZ) * `ATPG_TICK_US)
`endif

// ### logic/atpg_pkg.sv
package atpg_pkg;
    typedef enum logic [1:0] {ATPG_IDLE, ATPG_DELAY, ATPG_WIDTH} atpg_shp_e;
    typedef logic [31:0] atpg_word_t;
endpackage

// ### logic/atpg_shp_if.sv
`timescale 1ns/1ps
interface atpg_shp_if;
    logic        trig;
    logic        tick;
    logic        halt;
    logic [31:0] width_us;
    logic [31:0] delay_us;
    logic [31:0] scale;
    logic        pulse;
    logic        busy;
    logic        discard;
    modport ctl (output trig, tick, halt, width_us, delay_us, scale, input pulse, busy, discard);
    modport shp (input trig, tick, halt, width_us, delay_us, scale, output pulse, busy, discard);
endinterface

// ### logic/atpg_shaper.sv
`timescale 1ns/1ps
`include "atpg_map.svh"
module atpg_shaper (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Control side
    atpg_shp_if.shp   s
);
    import atpg_pkg::*;

    atpg_shp_e   st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic [31:0] div_q, div_d;
    logic        take;

    // Downscale: only every Nth accepted event fires
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        div_d   = div_q;
        take    = 1'b0;
        s.discard = 1'b0;
        if (s.trig) begin
            if (st_q != ATPG_IDLE || s.halt) begin
                s.discard = 1'b1; // Busy: events are dropped, never queued [RULE20]
            end else if (div_q + 32'h1 >= s.scale) begin
                div_d = 32'h0;
                take  = 1'b1; // [RULE5]
            end else begin
                div_d = div_q + 32'h1;
            end
        end
        unique case (st_q)
            ATPG_IDLE: begin
                if (take) begin
                    cnt_d = s.delay_us; // Delay counted in microsecond ticks [RULE15] [RULE18]
                    st_d  = (s.delay_us == 32'h0) ? ATPG_WIDTH : ATPG_DELAY;
                    if (s.delay_us == 32'h0) begin
                        cnt_d = s.width_us;
                    end
                end
            end
            ATPG_DELAY: begin
                // Wait for one extra tick so a free-running prescaler never cuts the delay short
                if (s.tick) begin
                    if (cnt_q == 32'h0) begin // [RULE15] [RULE18]
                        st_d  = ATPG_WIDTH;
                        cnt_d = s.width_us;
                    end else begin
                        cnt_d = cnt_q - 32'h1;
                    end
                end
            end
            ATPG_WIDTH: begin
                // Width in microseconds, always finished even after stop [RULE6] [RULE11]
                if (s.tick) begin
                    if (cnt_q <= 32'h1) begin
                        st_d = ATPG_IDLE;
                    end else begin
                        cnt_d = cnt_q - 32'h1;
                    end
                end
            end
        endcase
        if (s.halt && st_q == ATPG_DELAY) begin
            st_d = ATPG_IDLE; // Pending pulse has not started yet, drop it
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q  <= ATPG_IDLE;
            cnt_q <= 32'h0;
            div_q <= 32'h0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            div_q <= div_d;
        end
    end

    assign s.pulse = (st_q == ATPG_WIDTH);
    assign s.busy  = (st_q != ATPG_IDLE);

    a_width_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(s.pulse) |-> s.pulse [*2]) else $error("pulse shorter than two cycles"); // [RULE6]
    a_busy_drop: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.trig && s.busy) |-> s.discard) else $error("busy event not discarded"); // [RULE20]
endmodule

// ### logic/atpg_top.sv
//Contract
//RULE1 - Four front inputs indexed 0 to 3, two front outputs.
//RULE2 - Each front output routes to any shaper or a general input.
//RULE3 - Generator mode makes pulses from the internal frequency generator.
//RULE4 - Generator rate equals pulse_rate_hz in hertz.
//RULE5 - Four shapers, each with width, delay and downscale.
//RULE6 - Shaper width counts in microseconds.
//RULE7 - Camera route picks a shaper, true or inverted.
//RULE8 - No pulses until trigger_run_state is written active.
//RULE9 - Frames arriving before acquisition starts are dropped.
//RULE10 - Width longer than trigger period is rejected, flagged, old value kept.
//RULE11 - Finish-then-halt completes current pulse, then suppresses output.
//RULE12 - External mode: generator silent, events only from chosen input.
//RULE13 - External mode uses source select and edge polarity.
//RULE14 - Low-active: falling edges only; input pulse length ignored.
//RULE15 - Per-shaper delay between event and output pulse start.
//RULE16 - Camera exposes while trigger stays asserted.
//RULE17 - Outside generator mode, pulse_rate_hz caps rate; excess rejected.
//RULE18 - Shaper delay counts in microseconds.
//RULE19 - Timing from system clock via one-microsecond prescaler.
//RULE20 - Events during delay or width are discarded and counted.
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "atpg_map.svh"
module atpg_top #(
    parameter int NUM_IN   = 4,
    parameter int NUM_SHP  = 4,
    parameter int US_PER_S = 1000000
) (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // Wishbone slave
    input  wire logic                     cyc_i,
    input  wire logic                     stb_i,
    input  wire logic                     we_i,
    input  wire logic [7:0]               adr_i,
    input  wire logic [3:0]               sel_i,
    input  wire atpg_pkg::atpg_word_t     dat_i,
    output logic      [31:0]              dat_o,
    output logic                          ack_o,
    // Front inputs and outputs
    input  wire logic [NUM_IN-1:0]        general_input_i,
    output logic      [1:0]               front_out_o,
    // Camera link
    output logic                          camera_trig_o,
    input  wire logic                     frame_valid_i,
    output logic                          frame_accept_o
);
    import atpg_pkg::*;

    atpg_shp_if shp_if [NUM_SHP] ();

    // Register state
    logic [11:0] ctrl_q, ctrl_d;
    logic [31:0] rate_q, rate_d;
    logic [11:0] route_q, route_d;
    logic        acq_q, acq_d;
    logic        err_q, err_d;
    logic [31:0] disc_q, disc_d;
    logic [31:0] width_q [NUM_SHP];
    logic [31:0] width_d [NUM_SHP];
    logic [31:0] delay_q [NUM_SHP];
    logic [31:0] delay_d [NUM_SHP];
    logic [31:0] scale_q [NUM_SHP];
    logic [31:0] scale_d [NUM_SHP];
    logic        ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    // Timing state
    logic [7:0]  pre_q, pre_d;
    logic [31:0] per_q, per_d;
    logic        in_q, in_d;
    logic        halting_q, halting_d;

    logic [1:0]  run;
    logic        gen_mode;
    logic        tick;
    logic [31:0] period_us;
    logic        sel_in;
    logic        edge_ev;
    logic        gen_ev;
    logic        ev;
    logic [NUM_SHP-1:0] pulse_v;
    logic [NUM_SHP-1:0] busy_v;
    logic [NUM_SHP-1:0] disc_v;
    logic        wr, rd_req;

    assign run      = ctrl_q[`ATPG_CTRL_RUN_LO +: 2];
    assign gen_mode = ctrl_q[`ATPG_CTRL_MODE];
    assign wr       = cyc_i && stb_i && we_i && !ack_q;
    assign rd_req   = cyc_i && stb_i && !ack_q;

    // Period in microseconds derived from the rate setting
    assign period_us = (rate_q == 32'h0) ? 32'hffffffff : 32'(US_PER_S) / rate_q; // [RULE4]

    // Decode a route selector into a pin level
    function automatic logic route_pick(input logic [3:0] code, input logic [NUM_SHP-1:0] p,
                                        input logic [NUM_IN-1:0] g);
        logic r;
        r = 1'b0;
        if (code >= `ATPG_SEL_GPI) begin
            r = g[code[1:0]];
        end else if (code >= `ATPG_SEL_INV) begin
            r = !p[code[1:0]];
        end else begin
            r = p[code[1:0]];
        end
        return r;
    endfunction

    // Source select and edge polarity: only the chosen edge makes an event
    always_comb begin
        sel_in  = general_input_i[ctrl_q[`ATPG_CTRL_SRC_LO +: 2]]; // [RULE1] [RULE13]
        in_d    = sel_in;
        edge_ev = ctrl_q[`ATPG_CTRL_POL] ? (in_q && !sel_in) : (!in_q && sel_in); // [RULE14]
    end

    // Microsecond prescaler and period counter
    always_comb begin
        pre_d = pre_q + 8'h1;
        tick  = 1'b0;
        if (pre_q == 8'(`ATPG_TICK_CYC - 1)) begin
            pre_d = 8'h0;
            tick  = 1'b1; // [RULE19]
        end
        per_d  = per_q;
        gen_ev = 1'b0;
        ev     = 1'b0;
        if (tick && per_q != 32'h0) begin
            per_d = per_q - 32'h1;
        end
        if (run == `ATPG_RUN_ACTIVE) begin // [RULE8]
            if (gen_mode) begin
                if (tick && per_q <= 32'h1) begin
                    gen_ev = 1'b1; // [RULE3]
                    per_d  = period_us;
                end
                ev = gen_ev;
            end else if (edge_ev) begin
                // Generator silent; events only from the input, capped by rate [RULE12] [RULE17]
                if (per_q == 32'h0) begin
                    ev    = 1'b1;
                    per_d = period_us;
                end
            end
        end
    end

    // Shaper instances
    generate
        for (genvar i = 0; i < NUM_SHP; i++) begin : g_shp
            assign shp_if[i].trig     = ev;
            assign shp_if[i].tick     = tick;
            assign shp_if[i].halt     = (run != `ATPG_RUN_ACTIVE);
            assign shp_if[i].width_us = width_q[i];
            assign shp_if[i].delay_us = delay_q[i];
            assign shp_if[i].scale    = scale_q[i];
            assign pulse_v[i]         = shp_if[i].pulse;
            assign busy_v[i]          = shp_if[i].busy;
            assign disc_v[i]          = shp_if[i].discard;
            atpg_shaper u_shp (
                .clk_i (clk_i),
                .rst_i (rst_i),
                .s     (shp_if[i].shp)
            );
        end
    endgenerate

    // Register writes, reads and halt completion
    always_comb begin
        ctrl_d    = ctrl_q;
        rate_d    = rate_q;
        route_d   = route_q;
        acq_d     = acq_q;
        err_d     = err_q;
        disc_d    = disc_q + 32'($countones(disc_v)); // [RULE20]
        width_d   = width_q;
        delay_d   = delay_q;
        scale_d   = scale_q;
        halting_d = halting_q;
        ack_d     = rd_req;
        rdat_d    = 32'h0;
        if (halting_q && busy_v == '0) begin
            halting_d = 1'b0; // Current pulse done, stay halted [RULE11]
        end
        if (wr) begin
            unique case (adr_i)
                `ATPG_REG_CTRL: begin
                    ctrl_d = dat_i[11:0];
                    if (dat_i[`ATPG_CTRL_RUN_LO +: 2] == `ATPG_RUN_HALT) begin
                        halting_d = 1'b1; // [RULE11]
                    end
                end
                `ATPG_REG_RATE:  rate_d  = dat_i;
                `ATPG_REG_ROUTE: route_d = dat_i[11:0];
                `ATPG_REG_ACQ:   acq_d   = dat_i[0];
                `ATPG_REG_STATUS: err_d  = 1'b0;
                default: begin
                    for (int i = 0; i < NUM_SHP; i++) begin
                        if (adr_i[7:4] == 4'(i + 2)) begin
                            if (adr_i[3:2] == `ATPG_SHP_WIDTH) begin
                                if (dat_i > period_us) begin
                                    err_d = 1'b1; // Reject, old width kept [RULE10]
                                end else begin
                                    width_d[i] = dat_i;
                                end
                            end else if (adr_i[3:2] == `ATPG_SHP_DELAY) begin
                                delay_d[i] = dat_i;
                            end else if (adr_i[3:2] == `ATPG_SHP_SCALE) begin
                                scale_d[i] = dat_i;
                            end
                        end
                    end
                end
            endcase
        end else if (rd_req) begin
            unique case (adr_i)
                `ATPG_REG_CTRL:     rdat_d = {20'h0, ctrl_q};
                `ATPG_REG_RATE:     rdat_d = rate_q;
                `ATPG_REG_ROUTE:    rdat_d = {20'h0, route_q};
                `ATPG_REG_STATUS:   rdat_d = {26'h0, halting_q, err_q, busy_v};
                `ATPG_REG_DISCARDS: rdat_d = disc_q;
                `ATPG_REG_ACQ:      rdat_d = {31'h0, acq_q};
                default: begin
                    for (int i = 0; i < NUM_SHP; i++) begin
                        if (adr_i[7:4] == 4'(i + 2)) begin
                            if (adr_i[3:2] == `ATPG_SHP_WIDTH) rdat_d = width_q[i];
                            else if (adr_i[3:2] == `ATPG_SHP_DELAY) rdat_d = delay_q[i];
                            else if (adr_i[3:2] == `ATPG_SHP_SCALE) rdat_d = scale_q[i];
                        end
                    end
                end
            endcase
        end
    end

    // Register all state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q    <= 12'h0;
            rate_q    <= `ATPG_RATE_RST;
            route_q   <= 12'h0;
            acq_q     <= 1'b0;
            err_q     <= 1'b0;
            disc_q    <= 32'h0;
            ack_q     <= 1'b0;
            rdat_q    <= 32'h0;
            pre_q     <= 8'h0;
            per_q     <= 32'h0;
            in_q      <= 1'b0;
            halting_q <= 1'b0;
            for (int i = 0; i < NUM_SHP; i++) begin
                width_q[i] <= `ATPG_WIDTH_RST;
                delay_q[i] <= 32'h0;
                scale_q[i] <= `ATPG_SCALE_RST;
            end
        end else begin
            ctrl_q    <= ctrl_d;
            rate_q    <= rate_d;
            route_q   <= route_d;
            acq_q     <= acq_d;
            err_q     <= err_d;
            disc_q    <= disc_d;
            ack_q     <= ack_d;
            rdat_q    <= rdat_d;
            pre_q     <= pre_d;
            per_q     <= per_d;
            in_q      <= in_d;
            halting_q <= halting_d;
            width_q   <= width_d;
            delay_q   <= delay_d;
            scale_q   <= scale_d;
        end
    end

    // Output routing; shaper-true routes stay quiet until first activation, inverted and general input routes do not
    always_comb begin
        camera_trig_o  = route_pick(route_q[`ATPG_ROUTE_CAM_LO +: 4], pulse_v, general_input_i); // [RULE7] [RULE16]
        front_out_o[0] = route_pick(route_q[`ATPG_ROUTE_OUT0_LO +: 4], pulse_v, general_input_i); // [RULE2]
        front_out_o[1] = route_pick(route_q[`ATPG_ROUTE_OUT1_LO +: 4], pulse_v, general_input_i);
        frame_accept_o = frame_valid_i && acq_q; // [RULE9]
    end

    assign ack_o = ack_q;
    assign dat_o = rdat_q;

    a_idle_silent: assert property (@(posedge clk_i) disable iff (rst_i)
        (run == `ATPG_RUN_IDLE && busy_v == '0) |=> (pulse_v == '0)) else $error("pulse while idle"); // [RULE8]
    a_ext_no_gen: assert property (@(posedge clk_i) disable iff (rst_i)
        !gen_mode |-> !gen_ev) else $error("generator fired in external mode"); // [RULE12]
    a_frame_drop: assert property (@(posedge clk_i) disable iff (rst_i)
        !acq_q |-> !frame_accept_o) else $error("frame accepted before acquisition"); // [RULE9]
    a_width_reject: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && adr_i == `ATPG_REG_SHP_BASE && dat_i > period_us) |=> (err_q && $stable(width_q[0])))
        else $error("overlong width accepted"); // [RULE10]
endmodule

// ### tb/atpg_cam_model.sv
`timescale 1ns/1ps
// Camera in external trigger mode: exposes while trigger is high
module atpg_cam_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Trigger from the card
    input  wire logic        trig_i,
    // Frame strobe back to the card
    output logic             frame_valid_o,
    // Observed figures for the bench
    output logic [31:0]      pulses_o,
    output logic [31:0]      expo_o,
    output logic [31:0]      period_o
);
    logic        trig_q;
    logic [31:0] since_q;
    logic [31:0] high_q;

    // Exposure starts on the rising edge, lasts while asserted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_q        <= 1'b0;
            frame_valid_o <= 1'b0;
            pulses_o      <= 32'h0;
            expo_o        <= 32'h0;
            period_o      <= 32'h0;
            since_q       <= 32'h0;
            high_q        <= 32'h0;
        end else begin
            trig_q        <= trig_i;
            frame_valid_o <= 1'b0;
            since_q       <= since_q + 32'h1;
            high_q        <= high_q + 32'h1;
            if (trig_i && !trig_q) begin
                pulses_o <= pulses_o + 32'h1;
                period_o <= since_q;
                since_q  <= 32'h1;
                high_q   <= 32'h1;
            end
            // Frame leaves the sensor once exposure ends
            if (!trig_i && trig_q) begin
                expo_o        <= high_q;
                frame_valid_o <= 1'b1;
            end
        end
    end
endmodule

// ### tb/tb_atpg_top.sv
`timescale 1ns/1ps
`include "atpg_map.svh"
module tb_atpg_top;
    import atpg_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'hf;
    atpg_word_t  dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [3:0]  gin   = 4'hf;
    logic [1:0]  front_out_o;
    logic        camera_trig_o;
    logic        frame_valid_i;
    logic        frame_accept_o;
    logic [31:0] pulses, expo, period;
    logic [31:0] frames_n = 32'h0;
    logic [31:0] acc_n    = 32'h0;
    logic [31:0] out1_n   = 32'h0;
    logic        o1_q     = 1'b0;
    logic [31:0] rd, p, d0, o1;
    int          err_total   = 0;
    int          checks_done = 0;
    int          n;

    always #12.5 clk_i = ~clk_i;

    atpg_top u_atpg_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .general_input_i(gin), .front_out_o(front_out_o), .camera_trig_o(camera_trig_o),
        .frame_valid_i(frame_valid_i), .frame_accept_o(frame_accept_o));

    atpg_cam_model u_atpg_cam_model (.clk_i(clk_i), .rst_i(rst_i), .trig_i(camera_trig_o),
        .frame_valid_o(frame_valid_i), .pulses_o(pulses), .expo_o(expo), .period_o(period));

    // Frame and front output bookkeeping
    always @(posedge clk_i) begin
        o1_q <= front_out_o[1];
        if (frame_valid_i) frames_n <= frames_n + 32'h1;
        if (frame_valid_i && frame_accept_o) acc_n <= acc_n + 32'h1;
        if (front_out_o[1] && !o1_q) out1_n <= out1_n + 32'h1;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Classic cycle: hold until ack is sampled, then release
    task automatic wb(input logic wr, input logic [7:0] a, input atpg_word_t d, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= wr; adr_i <= a; dat_i <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        q = dat_o;
        if (k >= 50) err_total++;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input atpg_word_t d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge clk_i);
    endtask

    task automatic wait_rise(output int c);
        c = 0;
        while (camera_trig_o !== 1'b1 && c < 9000) begin
            @(posedge clk_i);
            c++;
        end
    endtask

    // Falling edge on source input; low time is short
    task automatic ev(input int gap);
        gin[2] <= 1'b0;
        idle(40);
        gin[2] <= 1'b1;
        idle(gap);
    endtask

    task automatic wrap_up;
        $display("mismatches=%0d comparisons=%0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Watchdog sized well above the longest sequence
    initial begin
        #(25.0 * 90000);
        err_total++;
        wrap_up();
    end

    initial begin
        idle(2);
        rst_i <= 1'b0;
        // Reset values and an unmapped place
        wb(0, `ATPG_REG_RATE, 0, rd);       chk(rd, `ATPG_RATE_RST);
        wb(0, 8'h20, 0, rd);                chk(rd, `ATPG_WIDTH_RST);
        wb(0, 8'h28, 0, rd);                chk(rd, 32'h1);
        wr(8'h18, 32'h5);
        wb(0, 8'h18, 0, rd);                chk(rd, 32'h0);
        // Generator configured but idle
        wr(8'h20, 32'd20);
        wr(`ATPG_REG_RATE, 32'd10000);
        wr(`ATPG_REG_CTRL, 32'h001);
        p = pulses;
        idle(9000);                         chk(pulses, p);
        // Width beyond the 100 us period
        wr(8'h20, 32'd150);
        wb(0, 8'h20, 0, rd);                chk(rd, 32'd20);
        wb(0, `ATPG_REG_STATUS, 0, rd);     chk(rd & 32'h10, 32'h10);
        wr(`ATPG_REG_STATUS, 32'h0);
        wr(`ATPG_REG_CTRL, 32'h101);
        idle(9000);
        chk(period, 32'd4000);
        chk(expo, 32'd800);
        chk(acc_n, 32'h0);
        chk({31'h0, frames_n != 0}, 32'h1);
        wr(`ATPG_REG_ACQ, 32'h1);
        idle(4500);                         chk({31'h0, acc_n != 0}, 32'h1);
        // Halt in mid pulse
        wait_rise(n);
        idle(100);
        wr(`ATPG_REG_CTRL, 32'h201);
        p = pulses + 32'h0;
        idle(9000);
        chk(pulses, p);
        chk(expo, 32'd800);
        wr(`ATPG_REG_ROUTE, 32'h4);
        idle(1);                            chk({31'h0, camera_trig_o}, 32'h1);
        wr(`ATPG_REG_ROUTE, 32'h0);
        // External, low-active, source 2, 25 us rate cap
        wr(`ATPG_REG_RATE, 32'd40000);
        wr(8'h24, 32'd10);
        wr(8'h30, 32'd5);
        wr(8'h38, 32'd2);
        // Short widths on shapers 2 and 3 so they never discard here
        wr(8'h40, 32'd5);
        wr(8'h50, 32'd5);
        wr(`ATPG_REG_ROUTE, 32'h1a0);
        wr(`ATPG_REG_CTRL, 32'h122);
        idle(2000);
        p = pulses;
        chk({31'h0, front_out_o[0]}, 32'h1);
        gin[1] <= 1'b0;
        idle(2000);
        gin[1] <= 1'b1;
        idle(2000);                         chk(pulses, p);
        gin[2] <= 1'b0;
        wait_rise(n);
        chk({31'h0, n >= 400 && n <= 445}, 32'h1);
        chk({31'h0, front_out_o[0]}, 32'h0);
        idle(3000);                         chk(expo, 32'd800);
        gin[2] <= 1'b1;
        idle(2000);                         chk(pulses, p + 32'h1);
        // Second event while busy, past the rate cap
        wb(0, `ATPG_REG_DISCARDS, 0, d0);
        ev(1040);
        ev(3000);
        wb(0, `ATPG_REG_DISCARDS, 0, rd);   chk(rd, d0 + 32'h1);
        chk(pulses, p + 32'h2);
        // Second event faster than the rate cap
        ev(360);
        ev(3000);
        wb(0, `ATPG_REG_DISCARDS, 0, rd);   chk(rd, d0 + 32'h1);
        chk(pulses, p + 32'h3);
        // Shaper 1 downscaled by two on front output 1
        o1 = out1_n;
        repeat (4) ev(2000);
        chk(pulses, p + 32'h7);
        chk(out1_n, o1 + 32'h2);
        wrap_up();
    end
endmodule
